/* File: rtl/pmdis_defs.vh */
// register offsets, field positions, masks and timing counts of the module gate bank
`ifndef PMDIS_DEFS_VH
`define PMDIS_DEFS_VH

// ----------------------------------------------------------------------
// register offsets (word index on the plain port)
// ----------------------------------------------------------------------
`define PMDIS_OFS_CTRL_1      3'h0
`define PMDIS_OFS_CTRL_2      3'h1
`define PMDIS_OFS_CTRL_3      3'h2
`define PMDIS_OFS_CTRL_4      3'h3
`define PMDIS_OFS_CTRL_6      3'h5
`define PMDIS_OFS_CTRL_7      3'h6

// ----------------------------------------------------------------------
// writable bit masks (unimplemented bits read zero, ignore writes)
// ----------------------------------------------------------------------
`define PMDIS_MASK_1          16'hFEFB
`define PMDIS_MASK_2          16'h0F0F
`define PMDIS_MASK_3          16'h0482
`define PMDIS_MASK_4          16'h000C
`define PMDIS_MASK_6          16'h0700
`define PMDIS_MASK_7          16'h0018

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PMDIS_RST_VALUE       16'h0000

// ----------------------------------------------------------------------
// field positions, register 1
// ----------------------------------------------------------------------
`define PMDIS_B1_TIMER_HI     15
`define PMDIS_B1_TIMER_LO     11
`define PMDIS_B1_ENCODER      10
`define PMDIS_B1_MOTOR_PWM    9
`define PMDIS_B1_I2C_FIRST    7
`define PMDIS_B1_UART_SECOND  6
`define PMDIS_B1_UART_FIRST   5
`define PMDIS_B1_SPI_SECOND   4
`define PMDIS_B1_SPI_FIRST    3
`define PMDIS_B1_CAN          1
`define PMDIS_B1_CONVERTER    0

// ----------------------------------------------------------------------
// field positions, registers 2, 3, 4, 6, 7
// ----------------------------------------------------------------------
`define PMDIS_B2_CAPTURE_HI   11
`define PMDIS_B2_CAPTURE_LO   8
`define PMDIS_B2_COMPARE_HI   3
`define PMDIS_B2_COMPARE_LO   0
`define PMDIS_B3_COMPARATOR   10
`define PMDIS_B3_CHECKSUM     7
`define PMDIS_B3_I2C_SECOND   1
`define PMDIS_B4_REF_CLOCK    3
`define PMDIS_B4_CHARGE_TIMER 2
`define PMDIS_B6_PWM_GEN_HI   10
`define PMDIS_B6_PWM_GEN_LO   8
`define PMDIS_B7_DMA_ALL      4
`define PMDIS_B7_TRIGGER_GEN  3

// ----------------------------------------------------------------------
// timing: one instruction cycle of delay, counted in delay stages (instruction cycles), not system clocks
// ----------------------------------------------------------------------
`define PMDIS_INSTR_CLOCKS    1

`endif

/* File: rtl/pmdis_delay.v */
// delay line that applies gate changes one instruction cycle late
`timescale 1ns/1ps

module pmdis_delay #(
   parameter WIDTH  = 1,
   parameter STAGES = 1
) (
   input  wire             mclk,
   input  wire             sys_rst,
   input  wire             instr_tick,
   input  wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] dout
);

   // ----------------------------------------------------------------------
   // one register stage per instruction cycle of delay
   // ----------------------------------------------------------------------
   reg [WIDTH-1:0] stage [0:STAGES-1];

   genvar g;
   generate
      for (g = 0; g < STAGES; g = g + 1) begin : g_stage
         wire [WIDTH-1:0] src;
         // first stage takes the input, later ones the stage before
         if (g == 0) begin : g_first
            assign src = din;
         end else begin : g_next
            assign src = stage[g-1];
         end
         always @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               stage[g] <= {WIDTH{1'b0}};
            end else if (instr_tick) begin
               stage[g] <= src;
            end
         end
      end
   endgenerate

   assign dout = stage[STAGES-1];

endmodule

/* File: rtl/pmdis_bank.v */
// peripheral module disable register bank with per-module clock gates
// How it works
// RULE_01: set bit disables module one instruction later
// RULE_02: cleared bit re-enables module one instruction later
// RULE_03: reg1 bits 15..9 gate timers, encoder, pwm
// RULE_04: reg1 bits 7..3 gate i2c, uarts, spis
// RULE_05: reg1 bit1 gates can, bit0 converter
// RULE_06: reg3 bits 10,7,1 gate comparator, crc, i2c
// RULE_07: reg4 bit3 gates reference clock output
// RULE_08: reg4 bit2 gates charge time unit
// RULE_09: reg7 bit4 all dma, bit3 trigger
// RULE_10: unimplemented bits read zero, ignore writes
// RULE_11: disabled module gets no clock, registers
// RULE_12: enabled only if bit clear and present
// RULE_13: reg2 gates capture and compare units
// RULE_14: reg6 gates pwm generators; reset zero
`timescale 1ns/1ps
`include "pmdis_defs.vh"

module pmdis_bank #(
   parameter        INSTR_DIV   = 2,
   parameter [15:0] PRESENT_1   = 16'hFEFB,
   parameter [15:0] PRESENT_2   = 16'h0F0F,
   parameter [15:0] PRESENT_3   = 16'h0482,
   parameter [15:0] PRESENT_4   = 16'h000C,
   parameter [15:0] PRESENT_6   = 16'h0700,
   parameter [15:0] PRESENT_7   = 16'h0018
) (
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire [2:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   output reg  [4:0]  timer_clk_en,
   output reg         encoder_clk_en,
   output reg         motor_pwm_clk_en,
   output reg         i2c_first_clk_en,
   output reg         i2c_second_clk_en,
   output reg  [1:0]  uart_clk_en,
   output reg  [1:0]  spi_clk_en,
   output reg         can_ctrl_clk_en,
   output reg         converter_clk_en,
   output reg  [3:0]  capture_unit_clk_en,
   output reg  [3:0]  compare_unit_clk_en,
   output reg         comparator_clk_en,
   output reg         checksum_clk_en,
   output reg         ref_clock_out_clk_en,
   output reg         charge_timer_clk_en,
   output reg  [2:0]  pwm_gen_clk_en,
   output reg         dma_all_clk_en,
   output reg         trigger_gen_clk_en,
   output reg  [95:0] peripheral_gate_bit
);

   // ----------------------------------------------------------------------
   // effective masks: a bit exists only where hardware is present
   // ----------------------------------------------------------------------
   localparam [15:0] IMPL_1 = `PMDIS_MASK_1 & PRESENT_1;
   localparam [15:0] IMPL_2 = `PMDIS_MASK_2 & PRESENT_2;
   localparam [15:0] IMPL_3 = `PMDIS_MASK_3 & PRESENT_3;
   localparam [15:0] IMPL_4 = `PMDIS_MASK_4 & PRESENT_4;
   localparam [15:0] IMPL_6 = `PMDIS_MASK_6 & PRESENT_6;
   localparam [15:0] IMPL_7 = `PMDIS_MASK_7 & PRESENT_7;
   localparam [95:0] IMPL_ALL = {IMPL_7, IMPL_6, IMPL_4,
                                 IMPL_3, IMPL_2, IMPL_1};

   // ----------------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------------
   reg  [15:0] module_disable_ctrl_1;
   reg  [15:0] module_disable_ctrl_2;
   reg  [15:0] module_disable_ctrl_3;
   reg  [15:0] module_disable_ctrl_4;
   reg  [15:0] module_disable_ctrl_6;
   reg  [15:0] module_disable_ctrl_7;
   reg  [15:0] next_rdata;
   reg  [7:0]  div_cnt;
   reg         instr_tick;
   wire [95:0] ctrl_all;
   wire [95:0] gate_now;

   // instruction-cycle enable pulse from a divider of the system clock
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt    <= 8'h00;
         instr_tick <= 1'b0;
      end else if (div_cnt == INSTR_DIV[7:0] - 8'h01) begin
         div_cnt    <= 8'h00;
         instr_tick <= 1'b1;
      end else begin
         div_cnt    <= div_cnt + 8'h01;
         instr_tick <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------------
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         module_disable_ctrl_1 <= `PMDIS_RST_VALUE; // RULE_14
         module_disable_ctrl_2 <= `PMDIS_RST_VALUE;
         module_disable_ctrl_3 <= `PMDIS_RST_VALUE;
         module_disable_ctrl_4 <= `PMDIS_RST_VALUE;
         module_disable_ctrl_6 <= `PMDIS_RST_VALUE;
         module_disable_ctrl_7 <= `PMDIS_RST_VALUE;
      end else if (reg_wr) begin
         case (reg_addr)
            `PMDIS_OFS_CTRL_1: begin
               module_disable_ctrl_1 <= reg_wdata & IMPL_1; // RULE_10
            end
            `PMDIS_OFS_CTRL_2: begin
               module_disable_ctrl_2 <= reg_wdata & IMPL_2; // RULE_13
            end
            `PMDIS_OFS_CTRL_3: begin
               module_disable_ctrl_3 <= reg_wdata & IMPL_3;
            end
            `PMDIS_OFS_CTRL_4: begin
               module_disable_ctrl_4 <= reg_wdata & IMPL_4;
            end
            `PMDIS_OFS_CTRL_6: begin
               module_disable_ctrl_6 <= reg_wdata & IMPL_6; // RULE_14
            end
            `PMDIS_OFS_CTRL_7: begin
               module_disable_ctrl_7 <= reg_wdata & IMPL_7;
            end
            default: begin
               module_disable_ctrl_1 <= module_disable_ctrl_1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // register reads: data in the cycle after the strobe, zero otherwise
   // ----------------------------------------------------------------------
   always @* begin
      case (reg_addr)
         `PMDIS_OFS_CTRL_1: next_rdata = module_disable_ctrl_1;
         `PMDIS_OFS_CTRL_2: next_rdata = module_disable_ctrl_2;
         `PMDIS_OFS_CTRL_3: next_rdata = module_disable_ctrl_3;
         `PMDIS_OFS_CTRL_4: next_rdata = module_disable_ctrl_4;
         `PMDIS_OFS_CTRL_6: next_rdata = module_disable_ctrl_6;
         `PMDIS_OFS_CTRL_7: next_rdata = module_disable_ctrl_7;
         default:           next_rdata = 16'h0000; // RULE_10
      endcase
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------------
   // gate changes pass through one instruction cycle of delay
   // ----------------------------------------------------------------------
   assign ctrl_all = {module_disable_ctrl_7, module_disable_ctrl_6,
                      module_disable_ctrl_4, module_disable_ctrl_3,
                      module_disable_ctrl_2, module_disable_ctrl_1};

   pmdis_delay #(
      .WIDTH  (96),
      .STAGES (`PMDIS_INSTR_CLOCKS)
   ) u_delay (
      .mclk       (mclk),
      .sys_rst    (sys_rst),
      .instr_tick (instr_tick),
      .din        (ctrl_all),
      .dout       (gate_now)
   ); // RULE_01 RULE_02

   // ----------------------------------------------------------------------
   // clock enables: high only for present modules with bit clear
   // ----------------------------------------------------------------------
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         peripheral_gate_bit  <= 96'h0;
         timer_clk_en         <= 5'h00;
         encoder_clk_en       <= 1'b0;
         motor_pwm_clk_en     <= 1'b0;
         i2c_first_clk_en     <= 1'b0;
         i2c_second_clk_en    <= 1'b0;
         uart_clk_en          <= 2'h0;
         spi_clk_en           <= 2'h0;
         can_ctrl_clk_en      <= 1'b0;
         converter_clk_en     <= 1'b0;
         capture_unit_clk_en  <= 4'h0;
         compare_unit_clk_en  <= 4'h0;
         comparator_clk_en    <= 1'b0;
         checksum_clk_en      <= 1'b0;
         ref_clock_out_clk_en <= 1'b0;
         charge_timer_clk_en  <= 1'b0;
         pwm_gen_clk_en       <= 3'h0;
         dma_all_clk_en       <= 1'b0;
         trigger_gen_clk_en   <= 1'b0;
      end else begin
         // one vector of module enables, absent modules stay off
         peripheral_gate_bit  <= ~gate_now & IMPL_ALL; // RULE_12 RULE_11
         // register 1
         timer_clk_en <= ~gate_now[`PMDIS_B1_TIMER_HI:`PMDIS_B1_TIMER_LO]
                         & IMPL_1[`PMDIS_B1_TIMER_HI:`PMDIS_B1_TIMER_LO]; // RULE_03
         encoder_clk_en   <= ~gate_now[`PMDIS_B1_ENCODER]
                             & IMPL_1[`PMDIS_B1_ENCODER];
         motor_pwm_clk_en <= ~gate_now[`PMDIS_B1_MOTOR_PWM]
                             & IMPL_1[`PMDIS_B1_MOTOR_PWM];
         i2c_first_clk_en <= ~gate_now[`PMDIS_B1_I2C_FIRST]
                             & IMPL_1[`PMDIS_B1_I2C_FIRST]; // RULE_04
         uart_clk_en <= ~gate_now[`PMDIS_B1_UART_SECOND:`PMDIS_B1_UART_FIRST]
                        & IMPL_1[`PMDIS_B1_UART_SECOND:`PMDIS_B1_UART_FIRST];
         spi_clk_en  <= ~gate_now[`PMDIS_B1_SPI_SECOND:`PMDIS_B1_SPI_FIRST]
                        & IMPL_1[`PMDIS_B1_SPI_SECOND:`PMDIS_B1_SPI_FIRST];
         can_ctrl_clk_en  <= ~gate_now[`PMDIS_B1_CAN]
                             & IMPL_1[`PMDIS_B1_CAN]; // RULE_05
         converter_clk_en <= ~gate_now[`PMDIS_B1_CONVERTER]
                             & IMPL_1[`PMDIS_B1_CONVERTER];
         // register 2
         capture_unit_clk_en <=
            ~gate_now[16+`PMDIS_B2_CAPTURE_HI:16+`PMDIS_B2_CAPTURE_LO]
            & IMPL_2[`PMDIS_B2_CAPTURE_HI:`PMDIS_B2_CAPTURE_LO]; // RULE_13
         compare_unit_clk_en <=
            ~gate_now[16+`PMDIS_B2_COMPARE_HI:16+`PMDIS_B2_COMPARE_LO]
            & IMPL_2[`PMDIS_B2_COMPARE_HI:`PMDIS_B2_COMPARE_LO];
         // register 3
         comparator_clk_en <= ~gate_now[32+`PMDIS_B3_COMPARATOR]
                              & IMPL_3[`PMDIS_B3_COMPARATOR]; // RULE_06
         checksum_clk_en   <= ~gate_now[32+`PMDIS_B3_CHECKSUM]
                              & IMPL_3[`PMDIS_B3_CHECKSUM];
         i2c_second_clk_en <= ~gate_now[32+`PMDIS_B3_I2C_SECOND]
                              & IMPL_3[`PMDIS_B3_I2C_SECOND];
         // register 4
         ref_clock_out_clk_en <= ~gate_now[48+`PMDIS_B4_REF_CLOCK]
                                 & IMPL_4[`PMDIS_B4_REF_CLOCK]; // RULE_07
         charge_timer_clk_en  <= ~gate_now[48+`PMDIS_B4_CHARGE_TIMER]
                                 & IMPL_4[`PMDIS_B4_CHARGE_TIMER]; // RULE_08
         // register 6
         pwm_gen_clk_en <=
            ~gate_now[64+`PMDIS_B6_PWM_GEN_HI:64+`PMDIS_B6_PWM_GEN_LO]
            & IMPL_6[`PMDIS_B6_PWM_GEN_HI:`PMDIS_B6_PWM_GEN_LO]; // RULE_14
         // register 7
         dma_all_clk_en     <= ~gate_now[80+`PMDIS_B7_DMA_ALL]
                               & IMPL_7[`PMDIS_B7_DMA_ALL]; // RULE_09
         trigger_gen_clk_en <= ~gate_now[80+`PMDIS_B7_TRIGGER_GEN]
                               & IMPL_7[`PMDIS_B7_TRIGGER_GEN];
      end
   end

endmodule

/* File: verification/pmdis_bank_sva.sv */
// concurrent checks on the ports of the module gate bank
`timescale 1ns/1ps
`include "pmdis_defs.vh"

module pmdis_bank_sva (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic [2:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [4:0]  timer_clk_en,
   input wire logic        encoder_clk_en,
   input wire logic        motor_pwm_clk_en,
   input wire logic        i2c_first_clk_en,
   input wire logic        i2c_second_clk_en,
   input wire logic [1:0]  uart_clk_en,
   input wire logic [1:0]  spi_clk_en,
   input wire logic        can_ctrl_clk_en,
   input wire logic        converter_clk_en,
   input wire logic [3:0]  capture_unit_clk_en,
   input wire logic [3:0]  compare_unit_clk_en,
   input wire logic        comparator_clk_en,
   input wire logic        checksum_clk_en,
   input wire logic        ref_clock_out_clk_en,
   input wire logic        charge_timer_clk_en,
   input wire logic [2:0]  pwm_gen_clk_en,
   input wire logic        dma_all_clk_en,
   input wire logic        trigger_gen_clk_en,
   input wire logic [95:0] peripheral_gate_bit
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic [2:0] quiet;
   // ----------------------------------------------------------------------
   // cycles since the last write, saturating
   // ----------------------------------------------------------------------
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) quiet <= 3'h0;
      else if (reg_wr) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
   end
   a_rdata_idle: assert property
      (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside read slot");
   a_unmapped_read: assert property
      (reg_rd && (reg_addr == 3'h4 || reg_addr == 3'h7)
       |=> reg_rdata == 16'h0000)
      else $error("unmapped index returned data");
   a_unimpl_gate: assert property
      ((peripheral_gate_bit & ~{`PMDIS_MASK_7, `PMDIS_MASK_6,
       `PMDIS_MASK_4, `PMDIS_MASK_3, `PMDIS_MASK_2, `PMDIS_MASK_1})
       == 96'h0)
      else $error("absent module shows enabled");
   // the written value must stand one cycle to reach the delay stage
   a_disable_delay: assert property
      (reg_wr && reg_addr == 3'h0 && reg_wdata[0]
       ##1 !(reg_wr && reg_addr == 3'h0) |-> ##[2:3] !converter_clk_en)
      else $error("converter not gated in time");
   a_enable_delay: assert property
      (reg_wr && reg_addr == 3'h0 && !reg_wdata[0]
       ##1 !(reg_wr && reg_addr == 3'h0) |-> ##[2:3] converter_clk_en)
      else $error("converter not re-enabled in time");
   a_gate_quiet: assert property
      (quiet >= 3'h6 |-> $stable(peripheral_gate_bit))
      else $error("gates moved without a write");
   a_reg1_map: assert property
      (peripheral_gate_bit[15:0] == {timer_clk_en, encoder_clk_en,
       motor_pwm_clk_en, 1'h0, i2c_first_clk_en, uart_clk_en,
       spi_clk_en, 1'h0, can_ctrl_clk_en, converter_clk_en})
      else $error("first bank gate map differs");
   a_reg2_map: assert property
      (peripheral_gate_bit[27:16] ==
       {capture_unit_clk_en, 4'h0, compare_unit_clk_en})
      else $error("capture or compare gate map differs");
   a_reg3_map: assert property
      ({peripheral_gate_bit[42], peripheral_gate_bit[39],
       peripheral_gate_bit[33]} ==
       {comparator_clk_en, checksum_clk_en, i2c_second_clk_en})
      else $error("third bank gate map differs");
   a_reg4_map: assert property
      (peripheral_gate_bit[51:50] ==
       {ref_clock_out_clk_en, charge_timer_clk_en})
      else $error("fourth bank gate map differs");
   a_reg67_map: assert property
      ({peripheral_gate_bit[74:72], peripheral_gate_bit[84:83]} ==
       {pwm_gen_clk_en, dma_all_clk_en, trigger_gen_clk_en})
      else $error("sixth or seventh bank gate map differs");
endmodule

bind pmdis_bank pmdis_bank_sva pmdis_bank_sva_inst (.mclk(mclk),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .timer_clk_en(timer_clk_en), .encoder_clk_en(encoder_clk_en),
   .motor_pwm_clk_en(motor_pwm_clk_en), .i2c_first_clk_en(i2c_first_clk_en),
   .i2c_second_clk_en(i2c_second_clk_en), .uart_clk_en(uart_clk_en),
   .spi_clk_en(spi_clk_en), .can_ctrl_clk_en(can_ctrl_clk_en),
   .converter_clk_en(converter_clk_en),
   .capture_unit_clk_en(capture_unit_clk_en),
   .compare_unit_clk_en(compare_unit_clk_en),
   .comparator_clk_en(comparator_clk_en), .checksum_clk_en(checksum_clk_en),
   .ref_clock_out_clk_en(ref_clock_out_clk_en),
   .charge_timer_clk_en(charge_timer_clk_en),
   .pwm_gen_clk_en(pwm_gen_clk_en), .dma_all_clk_en(dma_all_clk_en),
   .trigger_gen_clk_en(trigger_gen_clk_en),
   .peripheral_gate_bit(peripheral_gate_bit));

/* File: verification/test_peripheral_module_disable.sv */
// self-checking bench for the module gate bank
`timescale 1ns/1ps
`include "pmdis_defs.vh"

module test_peripheral_module_disable;
   localparam [95:0] FULL = {`PMDIS_MASK_7, `PMDIS_MASK_6, `PMDIS_MASK_4,
      `PMDIS_MASK_3, `PMDIS_MASK_2, `PMDIS_MASK_1};
   localparam [17:0] ADDRS = {3'h6, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0};
   logic        mclk, sys_rst, reg_wr, reg_rd;
   logic [2:0]  reg_addr;
   logic [15:0] reg_wdata;
   wire  [15:0] reg_rdata;
   wire  [4:0]  tmr;
   wire  [3:0]  cap, cmp;
   wire  [2:0]  pwg;
   wire  [1:0]  urt, spi;
   wire         enc, mpw, i2a, i2b, can, cnv, cpr, crc, rfo, ctm, dma, trg;
   wire  [95:0] gate, named;
   int          bad_count, n_compared;

   assign named = {11'h0, dma, trg, 3'h0, 5'h0, pwg, 8'h0, 12'h0, rfo, ctm,
      2'h0, 5'h0, cpr, 2'h0, crc, 5'h0, i2b, 1'h0, 4'h0, cap, 4'h0, cmp,
      tmr, enc, mpw, 1'h0, i2a, urt, spi, 1'h0, can, cnv};

   pmdis_bank pmdis_bank_inst (.mclk(mclk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_clk_en(tmr),
      .encoder_clk_en(enc), .motor_pwm_clk_en(mpw), .i2c_first_clk_en(i2a),
      .i2c_second_clk_en(i2b), .uart_clk_en(urt), .spi_clk_en(spi),
      .can_ctrl_clk_en(can), .converter_clk_en(cnv),
      .capture_unit_clk_en(cap), .compare_unit_clk_en(cmp),
      .comparator_clk_en(cpr), .checksum_clk_en(crc),
      .ref_clock_out_clk_en(rfo), .charge_timer_clk_en(ctm),
      .pwm_gen_clk_en(pwg), .dma_all_clk_en(dma), .trigger_gen_clk_en(trg),
      .peripheral_gate_bit(gate));

   always #2.5 mclk = ~mclk;

   // ----------------------------------------------------------------------
   // bus cycles and comparison
   // ----------------------------------------------------------------------
   task automatic check(input logic [95:0] got, input logic [95:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1 check({80'h0, reg_rdata}, {80'h0, exp});
   endtask
   task automatic tally_and_finish;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset;
      for (int r = 0; r < 6; r++) rd(ADDRS[r*3 +: 3], 16'h0000);
      check(gate, FULL);
      check(named, FULL);
      $display("test reset values done");
   endtask
   task automatic t_masks;
      for (int r = 0; r < 6; r++) begin
         wr(ADDRS[r*3 +: 3], 16'hFFFF);
         rd(ADDRS[r*3 +: 3], FULL[r*16 +: 16]);
         wr(ADDRS[r*3 +: 3], 16'h0000);
         rd(ADDRS[r*3 +: 3], 16'h0000);
      end
      wr(3'h4, 16'hFFFF);
      rd(3'h4, 16'h0000);
      wr(3'h7, 16'hFFFF);
      rd(3'h7, 16'h0000);
      rd(3'h0, 16'h0000);
      $display("test masks and unmapped done");
   endtask
   task automatic t_delay;
      wr(3'h0, 16'h0001);
      @(posedge mclk);
      #1 check({95'h0, cnv}, 96'h1);
      repeat (2) @(posedge mclk);
      #1 check({95'h0, cnv}, 96'h0);
      wr(3'h0, 16'h0000);
      @(posedge mclk);
      #1 check({95'h0, cnv}, 96'h0);
      repeat (2) @(posedge mclk);
      #1 check({95'h0, cnv}, 96'h1);
      $display("test gate delay done");
   endtask
   task automatic t_map;
      logic [95:0] expv;
      for (int r = 0; r < 6; r++) begin
         for (int b = 0; b < 16; b++) begin
            if (FULL[r*16+b]) begin
               wr(ADDRS[r*3 +: 3], 16'h0001 << b);
               repeat (4) @(posedge mclk);
               expv = FULL & ~(96'h1 << (r*16+b));
               #1 check(named, expv);
               check(gate, expv);
            end
         end
         wr(ADDRS[r*3 +: 3], 16'h0000);
      end
      $display("test gate map done");
   endtask
   task automatic t_midreset;
      wr(3'h2, 16'hFFFF);
      wr(3'h6, 16'hFFFF);
      @(posedge mclk);
      sys_rst <= 1'h1;
      repeat (3) @(posedge mclk);
      #1 check(named, 96'h0);
      @(posedge mclk);
      sys_rst <= 1'h0;
      rd(3'h2, 16'h0000);
      rd(3'h6, 16'h0000);
      repeat (6) @(posedge mclk);
      #1 check(gate, FULL);
      $display("test reset in mid-run done");
   endtask

   initial begin
      mclk = 1'h0;
      sys_rst = 1'h1;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 3'h0;
      reg_wdata = 16'h0000;
      bad_count = 0;
      n_compared = 0;
      repeat (20) @(posedge mclk);
      sys_rst <= 1'h0;
      repeat (6) @(posedge mclk);
      t_reset();
      t_masks();
      t_delay();
      t_map();
      t_midreset();
      tally_and_finish();
   end

   initial begin
      #20000;
      bad_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule
